// ### shared/i2c_slave_defines.svh
// register map, field positions, reset values and timing counts of the i2c slave
`ifndef I2C_SLAVE_DEFINES_SVH
`define I2C_SLAVE_DEFINES_SVH
`define OFS_LINK_CONTROL        8'h00
`define OFS_LINK_STATUS_CONTROL 8'h04
`define OFS_SHIFT_DATA_BUFFER   8'h08
`define OFS_OWN_SLAVE_ADDRESS   8'h0c
`define OFS_TIMEOUT_CONTROL     8'h10
`define CTRL_ENABLE_BIT         1
`define CTRL_DEB_HI_BIT         3
`define CTRL_DEB_LO_BIT         2
`define TOC_ENABLE_BIT          7
`define TOC_FLAG_BIT            6
`define STATUS_RESET            8'h81
`define DEB_TWO_CLOCKS          3'h2
`define DEB_FOUR_CLOCKS         3'h4
`define TIMEOUT_UNIT_CYCLES     1024
`endif

// ### shared/i2c_slave_pkg.sv
// types shared by the i2c slave interface
package i2c_slave_pkg;
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_addr = 3'b001,
        st_aack = 3'b010,
        st_wait = 3'b011,
        st_rx   = 3'b100,
        st_rack = 3'b101,
        st_tx   = 3'b110,
        st_tack = 3'b111
    } link_state_t;

    // laid out in the bit order of the status/control register
    typedef struct packed {
        logic transfer_complete_flag;
        logic address_match_flag;
        logic bus_busy_flag;
        logic direction_select;
        logic transmit_ack_bit;
        logic read_write_flag;
        logic match_wake_enable;
        logic receive_ack_flag;
    } status_t;
endpackage : i2c_slave_pkg

// ### src/i2c_slave_interface.sv
// slave-only two-wire interface with apb register access
`include "i2c_slave_defines.svh"

module i2c_slave_interface #(
    parameter int TIMEOUT_UNIT = `TIMEOUT_UNIT_CYCLES
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   scl_i,
    output logic                        scl_o,
    output logic                        scl_oe,
    input  wire logic                   sda_i,
    output logic                        sda_o,
    output logic                        sda_oe,
    output logic                        wake_o,
    output logic                        byte_done_o,
    output i2c_slave_pkg::status_t      flags_o
);
    import i2c_slave_pkg::*;

    logic        scl_meta, scl_s, sda_meta, sda_s, sda_d;
    logic        scl_f, scl_fd;
    logic [2:0]  deb_cnt, deb_need;
    logic [7:0]  ctrl_r, addr_r, toc_r, buf_r, sr_r;
    status_t     st_r;
    link_state_t state_r;
    logic [3:0]  bit_cnt;
    logic        sda_oe_r, hold_r, en_d, wake_r, byte_done_r;
    logic        pready_r, pslverr_r;
    logic [31:0] prdata_r;
    logic [7:0]  rd_mux;
    logic        rd_hit;
    logic        to_run;
    logic [15:0] pre_cnt;
    logic [6:0]  tick_cnt;
    logic        en, en_rise, start_det, stop_det, rise, fall;
    logic        acc, wr, rd, wr_data, rd_data, wr_ctrl, wr_stat, wr_addr, wr_toc;
    logic        rel_tx, rel_rx, addr_hit, rx_done, tx_done, to_fire, kill;

    // two flip-flops on each pin before any logic looks at it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_meta <= 1'b1;
            scl_s    <= 1'b1;
            sda_meta <= 1'b1;
            sda_s    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_meta <= scl_i;
            scl_s    <= scl_meta;
            sda_meta <= sda_i;
            sda_s    <= sda_meta;
            sda_d    <= sda_s;
        end
    end

    // samples a new level must survive before it is taken
    always_comb begin
        unique case (ctrl_r[`CTRL_DEB_HI_BIT:`CTRL_DEB_LO_BIT])
            2'b00:   deb_need = 3'h0;
            2'b01:   deb_need = `DEB_TWO_CLOCKS;
            default: deb_need = `DEB_FOUR_CLOCKS;
        endcase
    end

    // clock debounce; a glitch shorter than the window restarts the count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_f   <= 1'b1;
            scl_fd  <= 1'b1;
            deb_cnt <= 3'h0;
        end else begin
            scl_fd <= scl_f;
            if (scl_s == scl_f) begin
                deb_cnt <= 3'h0;
            end else if (deb_cnt + 3'h1 >= deb_need) begin
                scl_f   <= scl_s;
                deb_cnt <= 3'h0;
            end else begin
                deb_cnt <= deb_cnt + 3'h1;
            end
        end
    end

    // bus conditions; sda is not filtered, only the clock is
    assign en        = ctrl_r[`CTRL_ENABLE_BIT];
    assign en_rise   = en & ~en_d;
    assign start_det = en & scl_f & scl_fd & sda_d & ~sda_s;
    assign stop_det  = en & scl_f & scl_fd & ~sda_d & sda_s;
    assign rise      = en & scl_f & ~scl_fd;
    assign fall      = en & ~scl_f & scl_fd;

    // apb decode; writes and read side effects land on the completing edge
    assign acc     = psel & penable & pready_r;
    assign wr      = acc & pwrite;
    assign rd      = acc & ~pwrite;
    assign wr_ctrl = wr & (paddr == `OFS_LINK_CONTROL);
    assign wr_stat = wr & (paddr == `OFS_LINK_STATUS_CONTROL);
    assign wr_data = wr & (paddr == `OFS_SHIFT_DATA_BUFFER);
    assign wr_addr = wr & (paddr == `OFS_OWN_SLAVE_ADDRESS);
    assign wr_toc  = wr & (paddr == `OFS_TIMEOUT_CONTROL);
    assign rd_data = rd & (paddr == `OFS_SHIFT_DATA_BUFFER);

    // stretch release by software buffer access
    assign rel_tx   = wr_data & st_r.direction_select & (state_r == st_wait);
    assign rel_rx   = rd_data & ~st_r.direction_select & (state_r == st_wait);
    assign addr_hit = (state_r == st_addr) & fall & (bit_cnt == 4'h8)
                      & (sr_r[7:1] == addr_r[7:1]);
    assign rx_done  = (state_r == st_rx) & fall & (bit_cnt == 4'h8);
    assign tx_done  = (state_r == st_tx) & fall & (bit_cnt == 4'h7);
    assign to_fire  = to_run & toc_r[`TOC_ENABLE_BIT]
                      & (tick_cnt > {1'b0, toc_r[5:0]});
    assign kill     = ~en | en_rise | to_fire;

    // link sequencer: address, ack, stretch, data bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r  <= st_idle;
            bit_cnt  <= 4'h0;
            sr_r     <= 8'h00;
            sda_oe_r <= 1'b0;
            hold_r   <= 1'b0;
        end else if (kill) begin
            state_r  <= st_idle;
            sda_oe_r <= 1'b0;
            hold_r   <= 1'b0;
        end else if (start_det) begin
            state_r  <= st_addr;
            bit_cnt  <= 4'h0;
            sda_oe_r <= 1'b0;
            hold_r   <= 1'b0;
        end else if (stop_det) begin
            state_r  <= st_idle;
            sda_oe_r <= 1'b0;
            hold_r   <= 1'b0;
        end else begin
            unique case (state_r)
                st_idle: begin
                    hold_r <= 1'b0;
                end
                st_addr: begin
                    if (rise) begin
                        sr_r    <= {sr_r[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (fall && bit_cnt == 4'h8) begin
                        sda_oe_r <= addr_hit;
                        state_r  <= addr_hit ? st_aack : st_idle;
                    end
                end
                st_aack: begin
                    if (fall) begin
                        sda_oe_r <= 1'b0;
                        hold_r   <= 1'b1;
                        state_r  <= st_wait;
                    end
                end
                st_wait: begin
                    if (rel_tx) begin
                        sr_r     <= pwdata[7:0];
                        sda_oe_r <= ~pwdata[7];
                        hold_r   <= 1'b0;
                        bit_cnt  <= 4'h0;
                        state_r  <= st_tx;
                    end else if (rel_rx) begin
                        hold_r  <= 1'b0;
                        bit_cnt <= 4'h0;
                        state_r <= st_rx;
                    end
                end
                st_rx: begin
                    if (rise) begin
                        sr_r    <= {sr_r[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (rx_done) begin
                        sda_oe_r <= ~st_r.transmit_ack_bit;
                        state_r  <= st_rack;
                    end
                end
                st_rack: begin
                    if (fall) begin
                        sda_oe_r <= 1'b0;
                        hold_r   <= 1'b1;
                        state_r  <= st_wait;
                    end
                end
                st_tx: begin
                    if (tx_done) begin
                        sda_oe_r <= 1'b0;
                        state_r  <= st_tack;
                    end else if (fall) begin
                        sr_r     <= {sr_r[6:0], 1'b0};
                        sda_oe_r <= ~sr_r[6];
                        bit_cnt  <= bit_cnt + 4'h1;
                    end
                end
                st_tack: begin
                    // master nack: leave data line free for its stop
                    if (fall) begin
                        hold_r  <= ~st_r.receive_ack_flag;
                        state_r <= st_r.receive_ack_flag ? st_idle : st_wait;
                    end
                end
            endcase
        end
    end

    // status flags; hardware sets beat software clears in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= status_t'(`STATUS_RESET);
        end else begin
            if (wr_stat) begin
                st_r.direction_select  <= pwdata[4];
                st_r.transmit_ack_bit  <= pwdata[3];
                st_r.match_wake_enable <= pwdata[1];
            end
            if (en_rise || to_fire) begin
                st_r.transfer_complete_flag <= 1'b1;
                st_r.address_match_flag     <= 1'b0;
                st_r.bus_busy_flag          <= 1'b0;
                st_r.read_write_flag        <= 1'b0;
                st_r.receive_ack_flag       <= 1'b1;
            end else begin
                if (rx_done || tx_done || stop_det) begin
                    st_r.transfer_complete_flag <= 1'b1;
                end else if (start_det || rd_data) begin
                    st_r.transfer_complete_flag <= 1'b0;
                end
                if (start_det) begin
                    st_r.address_match_flag <= 1'b0;
                    st_r.bus_busy_flag      <= 1'b1;
                end else if (stop_det) begin
                    st_r.bus_busy_flag <= 1'b0;
                end
                if (addr_hit) begin
                    st_r.address_match_flag <= 1'b1;
                    st_r.read_write_flag    <= sr_r[0];
                end
                if (state_r == st_tack && rise) begin
                    st_r.receive_ack_flag <= sda_s;
                end
            end
        end
    end

    // data buffer: software load, or a finished received byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_r <= 8'h00;
        end else if (rx_done) begin
            buf_r <= sr_r;
        end else if (wr_data) begin
            buf_r <= pwdata[7:0];
        end
    end

    // control, own address and timeout registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 8'h00;
            addr_r <= 8'h00;
            toc_r  <= 8'h00;
            en_d   <= 1'b0;
        end else begin
            en_d <= en;
            if (wr_ctrl) begin
                ctrl_r <= {4'h0, pwdata[3:1], 1'b0};
            end
            if (wr_addr) begin
                addr_r <= {pwdata[7:1], 1'b0};
            end
            if (wr_toc) begin
                toc_r[7]   <= pwdata[7];
                toc_r[5:0] <= pwdata[5:0];
            end
            // flag clears by writing zero; a new timeout wins
            toc_r[`TOC_FLAG_BIT] <= to_fire
                | (toc_r[`TOC_FLAG_BIT] & ~(wr_toc & ~pwdata[`TOC_FLAG_BIT]));
        end
    end

    // timeout: prescaled ticks since the last clock fall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_run   <= 1'b0;
            pre_cnt  <= 16'h0000;
            tick_cnt <= 7'h00;
        end else begin
            if (kill || start_det || stop_det) begin
                to_run <= 1'b0;
            end else if (addr_hit) begin
                to_run <= 1'b1;
            end
            if (fall || addr_hit) begin
                pre_cnt  <= 16'h0000;
                tick_cnt <= 7'h00;
            end else if (to_run) begin
                if (pre_cnt == 16'(TIMEOUT_UNIT - 1)) begin
                    pre_cnt  <= 16'h0000;
                    tick_cnt <= (tick_cnt == 7'h7f) ? tick_cnt : tick_cnt + 7'h01;
                end else begin
                    pre_cnt <= pre_cnt + 16'h0001;
                end
            end
        end
    end

    // read mux; reserved bits read zero
    always_comb begin
        rd_hit = 1'b1;
        unique case (paddr)
            `OFS_LINK_CONTROL:        rd_mux = {4'h0, ctrl_r[3:1], 1'b0};
            `OFS_LINK_STATUS_CONTROL: rd_mux = st_r;
            `OFS_SHIFT_DATA_BUFFER:   rd_mux = buf_r;
            `OFS_OWN_SLAVE_ADDRESS:   rd_mux = {addr_r[7:1], 1'b0};
            `OFS_TIMEOUT_CONTROL:     rd_mux = toc_r;
            default: begin
                rd_mux = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // apb answer after one wait state, so read data leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (psel && penable && !pready_r) begin
            pready_r  <= 1'b1;
            pslverr_r <= ~rd_hit;
            prdata_r  <= {24'h00_0000, rd_mux};
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // wake request and byte-done strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_r      <= 1'b0;
            byte_done_r <= 1'b0;
        end else begin
            wake_r      <= st_r.match_wake_enable & st_r.address_match_flag;
            byte_done_r <= rx_done | tx_done;
        end
    end

    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign scl_o       = 1'b0;
    assign scl_oe      = hold_r;
    assign sda_o       = 1'b0;
    assign sda_oe      = sda_oe_r;
    assign wake_o      = wake_r;
    assign byte_done_o = byte_done_r;
    assign flags_o     = st_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_start_busy: assert property (start_det && !kill |=> st_r.bus_busy_flag
        && !st_r.transfer_complete_flag) else $error("start not seen");
    a_stop_free: assert property (stop_det && !kill |=> !st_r.bus_busy_flag
        && st_r.transfer_complete_flag) else $error("stop not seen");
    a_read_clears: assert property (rd_data && !rx_done && !tx_done && !stop_det && !en_rise
        && !to_fire |=> !st_r.transfer_complete_flag) else $error("read left flag set");
    a_off_pins: assert property (!en |=> !sda_oe && !scl_oe)
        else $error("pins driven while off");
    a_en_rise: assert property (en_rise |=> (st_r & 8'he5) == `STATUS_RESET)
        else $error("flags kept on enable");
    a_deb_none: assert property (deb_need == 3'h0 && scl_s != scl_f
        |=> scl_f == $past(scl_s)) else $error("filter delayed");
    a_deb_four: assert property (deb_need == `DEB_FOUR_CLOCKS && scl_s != scl_f
        && $changed(scl_s) |=> $stable(scl_f) [*3]) else $error("filter too quick");
    a_addr_ack: assert property (addr_hit && !kill && !start_det && !stop_det
        |=> sda_oe && st_r.address_match_flag [*1]) else $error("no address ack");
    a_ack_level: assert property (state_r == st_rack
        |-> sda_oe == !st_r.transmit_ack_bit) else $error("ack level wrong");
    a_hold_match: assert property (state_r == st_wait |-> scl_oe)
        else $error("clock not held");
    a_addr_lsb: assert property (pready && !pwrite && paddr == `OFS_OWN_SLAVE_ADDRESS
        |-> prdata[0] == 1'b0) else $error("address bit0 set");

    c_match: cover property (addr_hit);
    c_rx_byte: cover property (rx_done ##[1:1000] rd_data);
    c_tx_byte: cover property (tx_done);
    c_timeout: cover property (to_fire);
endmodule : i2c_slave_interface

// ### tb/i2c_master_model.sv
// two-wire bus master model: open-drain lines with pull-ups, waits out clock stretching
module i2c_master_model (
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    output wire logic scl,
    output wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam realtime Q = 31.25;
    localparam realtime H = 62.5;
    logic scl_low  = 1'b0;
    logic sda_low  = 1'b0;
    int   hang_cnt = 0;
    // any party pulling low wins, otherwise the pull-up gives high
    assign scl = !(scl_low || scl_oe);
    assign sda = !(sda_low || sda_oe);
    // release the clock and wait, bounded, while the slave holds it
    task automatic rise;
        scl_low = 1'b0;
        for (int n = 0; n < 5000 && scl !== 1'b1; n++) #8;
        if (scl !== 1'b1) hang_cnt++;
    endtask : rise
    // data changes only in the low phase; sampled late in the high phase
    task automatic bit_xfer(input logic b, output logic s);
        sda_low = !b;
        #Q;
        rise;
        #H;
        s = sda;
        scl_low = 1'b1;
        #Q;
    endtask : bit_xfer
    // also serves as repeated start when the clock is low
    task automatic start_cond;
        sda_low = 1'b0;
        #Q;
        rise;
        #H;
        sda_low = 1'b1;
        #H;
        scl_low = 1'b1;
        #Q;
    endtask : start_cond
    task automatic stop_cond;
        sda_low = 1'b1;
        #Q;
        rise;
        #H;
        sda_low = 1'b0;
        #H;
    endtask : stop_cond
    // eight bits msb first, then the acknowledge bit
    task automatic xfer_byte(input logic [7:0] d, input logic ack_in,
                             output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], q[i]);
        bit_xfer(ack_in, ack);
    endtask : xfer_byte
endmodule : i2c_master_model

// ### tb/tb_top.sv
// self-checking bench: apb register tasks plus bus master model
`include "i2c_slave_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, scl, sda, scl_oe, sda_oe, wake_o, byte_done_o, err, ack;
    logic [7:0]  q;
    logic        scl_o, sda_o;
    int          bad_count = 0, n_tests = 0, done_cnt = 0;
    i2c_slave_pkg::status_t flags_o;

    initial begin
        forever #4 pclk = ~pclk;
    end
    // tally byte-end strobes, a one-cycle pulse
    always @(posedge pclk) begin
        if (byte_done_o === 1'b1) done_cnt++;
    end

    // short timeout unit keeps the stall test quick
    i2c_slave_interface #(.TIMEOUT_UNIT(4)) u_i2c_slave_interface (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .wake_o(wake_o), .byte_done_o(byte_done_o), .flags_o(flags_o));
    i2c_master_model u_i2c_master_model (
        .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));

    task automatic summarize;
        bad_count += u_i2c_master_model.hang_cnt;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // setup, then access held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge pclk);
        if (n == 16) begin
            bad_count++;
            summarize;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        check(rd, {24'h0, e});
    endtask : rdchk
    // flags and pins settle within a few clocks of a pin edge
    task automatic fchk(input logic [7:0] m, input logic [7:0] e);
        repeat (8) @(posedge pclk);
        check({24'h0, flags_o & m}, {24'h0, e});
    endtask : fchk
    task automatic pchk(input logic [1:0] e);
        check({30'h0, scl_oe, sda_oe}, {30'h0, e});
    endtask : pchk
    task automatic xb(input logic [7:0] d, input logic a);
        u_i2c_master_model.xfer_byte(d, a, q, ack);
    endtask : xb

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        check({24'h0, flags_o}, 32'h81);
        check({30'h0, scl_o, sda_o}, 32'h0);
        rdchk(`OFS_LINK_STATUS_CONTROL, 8'h81);
        rdchk(`OFS_OWN_SLAVE_ADDRESS, 8'h00);
        wr(`OFS_TIMEOUT_CONTROL, 8'h00);
        wr(8'h14, 8'h55);
        check({31'h0, err}, 32'h1);
        rdchk(8'h14, 8'h00);
        wr(`OFS_OWN_SLAVE_ADDRESS, 8'hff);
        rdchk(`OFS_OWN_SLAVE_ADDRESS, 8'hfe);
        wr(`OFS_OWN_SLAVE_ADDRESS, 8'h54);
        for (int m = 0; m < 4; m++) begin
            wr(`OFS_LINK_CONTROL, 8'(m * 4));
            rdchk(`OFS_LINK_CONTROL, 8'(m * 4));
        end
        // disabled: no answer, no busy
        u_i2c_master_model.start_cond;
        xb(8'h54, 1'b1);
        check({31'h0, ack}, 32'h1);
        fchk(8'h20, 8'h00);
        u_i2c_master_model.stop_cond;
        $display("test registers done");
        // slave receive, ack then withheld ack
        wr(`OFS_LINK_CONTROL, 8'h02);
        u_i2c_master_model.start_cond;
        fchk(8'ha0, 8'h20);
        xb(8'h54, 1'b1);
        check({31'h0, ack}, 32'h0);
        fchk(8'h44, 8'h40);
        pchk(2'b10);
        wr(`OFS_LINK_STATUS_CONTROL, 8'h00);
        apb(1'b0, `OFS_SHIFT_DATA_BUFFER, 8'h00);
        repeat (2) @(posedge pclk);
        pchk(2'b00);
        xb(8'ha5, 1'b1);
        check({31'h0, ack}, 32'h0);
        fchk(8'h80, 8'h80);
        check(32'(done_cnt), 32'h1);
        rdchk(`OFS_SHIFT_DATA_BUFFER, 8'ha5);
        fchk(8'h80, 8'h00);
        wr(`OFS_LINK_STATUS_CONTROL, 8'h08);
        xb(8'h3c, 1'b1);
        check({31'h0, ack}, 32'h1);
        rdchk(`OFS_SHIFT_DATA_BUFFER, 8'h3c);
        u_i2c_master_model.stop_cond;
        fchk(8'ha0, 8'h80);
        u_i2c_master_model.start_cond;
        xb(8'h66, 1'b1);
        check({31'h0, ack}, 32'h1);
        fchk(8'h40, 8'h00);
        u_i2c_master_model.stop_cond;
        $display("test receive done");
        // slave transmit, master acks then refuses
        u_i2c_master_model.start_cond;
        xb(8'h55, 1'b1);
        check({31'h0, ack}, 32'h0);
        fchk(8'h44, 8'h44);
        wr(`OFS_LINK_STATUS_CONTROL, 8'h10);
        wr(`OFS_SHIFT_DATA_BUFFER, 8'h3c);
        xb(8'hff, 1'b0);
        check({24'h0, q}, 32'h3c);
        fchk(8'h81, 8'h80);
        wr(`OFS_SHIFT_DATA_BUFFER, 8'hc3);
        xb(8'hff, 1'b1);
        check({24'h0, q}, 32'hc3);
        fchk(8'h01, 8'h01);
        pchk(2'b00);
        u_i2c_master_model.stop_cond;
        wr(`OFS_LINK_STATUS_CONTROL, 8'h18);
        wr(`OFS_LINK_CONTROL, 8'h00);
        wr(`OFS_LINK_CONTROL, 8'h02);
        rdchk(`OFS_LINK_STATUS_CONTROL, 8'h99);
        $display("test transmit done");
        // wake request on match, dropped when software clears it
        wr(`OFS_LINK_STATUS_CONTROL, 8'h02);
        u_i2c_master_model.start_cond;
        xb(8'h54, 1'b1);
        fchk(8'h42, 8'h42);
        check({31'h0, wake_o}, 32'h1);
        wr(`OFS_LINK_STATUS_CONTROL, 8'h00);
        fchk(8'h02, 8'h00);
        check({31'h0, wake_o}, 32'h0);
        apb(1'b0, `OFS_SHIFT_DATA_BUFFER, 8'h00);
        u_i2c_master_model.stop_cond;
        // stall after match: (5+1)*4 clocks then the block resets itself
        wr(`OFS_TIMEOUT_CONTROL, 8'h85);
        u_i2c_master_model.start_cond;
        xb(8'h54, 1'b1);
        repeat (40) @(posedge pclk);
        rdchk(`OFS_TIMEOUT_CONTROL, 8'hc5);
        fchk(8'h60, 8'h00);
        pchk(2'b00);
        u_i2c_master_model.stop_cond;
        $display("test wake and timeout done");
        summarize;
    end
endmodule : tb_top
